// [src/led_pwm_pkg.sv]
// Shared constants for the LED PWM and fading pin block
package led_pwm_pkg;
    // ------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ      = 40_000_000;
    localparam int unsigned PWM_CLK_HZ       = 2_000_000;
    localparam int unsigned PWM_DIV_CYCLES   = CORE_CLK_HZ / PWM_CLK_HZ;
    localparam int unsigned FADE_UNIT_US     = 1000;
    localparam int unsigned FADE_UNIT_CYCLES = (CORE_CLK_HZ / 1_000_000) * FADE_UNIT_US;
    localparam int unsigned STRAP_CYCLES     = 16;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_PINS  = 8;
    localparam int unsigned PWM_BITS  = 8;
    localparam int unsigned ADDR_BITS = 4;

    // ------------------------------------------------------------
    // Register word indexes
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MODE      = 4'h0;
    localparam logic [3:0] REG_POLARITY  = 4'h1;
    localparam logic [3:0] REG_POWERUP   = 4'h2;
    localparam logic [3:0] REG_ON_INT    = 4'h3;
    localparam logic [3:0] REG_OFF_INT   = 4'h4;
    localparam logic [3:0] REG_FUNCTION  = 4'h5;
    localparam logic [3:0] REG_FADE      = 4'h6;
    localparam logic [3:0] REG_HOST_PWM  = 4'h7;
    localparam logic [3:0] REG_HOST_CMD  = 4'h8;
    localparam logic [3:0] REG_PROX_INT  = 4'h9;
    localparam logic [3:0] REG_STATUS    = 4'hA;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned FN_AUTO_LSB  = 0;
    localparam int unsigned FN_LOG_LSB   = 8;
    localparam int unsigned FN_CONT_LSB  = 16;
    localparam int unsigned FN_TRIPLE_LSB = 24;
    localparam int unsigned FD_INC_T_LSB = 0;
    localparam int unsigned FD_INC_F_LSB = 8;
    localparam int unsigned FD_DEC_T_LSB = 12;
    localparam int unsigned FD_DEC_F_LSB = 20;
    localparam int unsigned FD_DELAY_LSB = 24;
    localparam int unsigned HP_SEL_LSB   = 0;
    localparam int unsigned HP_LEVEL_LSB = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MODE     = 16'h0000;
    localparam logic [7:0]  RST_POLARITY = 8'hFF;
    localparam logic [7:0]  RST_POWERUP  = 8'h00;
    localparam logic [7:0]  RST_ON_INT   = 8'hFF;
    localparam logic [7:0]  RST_OFF_INT  = 8'h00;
    localparam logic [31:0] RST_FUNCTION = 32'h0000_00FF;
    localparam logic [31:0] RST_FADE     = 32'h0000_0000;
    localparam logic [7:0]  RST_PROX_INT = 8'h40;

    // Per-pin operating mode, two bits each in the mode register
    typedef enum logic [1:0] {
        fading_output_mode  = 2'h0,
        host_pwm_mode       = 2'h1,
        special_output_mode = 2'h2
    } pin_mode_e;
endpackage

// [src/pwm_channel.sv]
// One 8-bit PWM generator with linear and logarithmic intensity mapping
`timescale 1ns/1ps
module pwm_channel
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       pwm_tick_i,
    input  wire logic [7:0] level_i,
    input  wire logic       log_sel_i,
    input  wire logic       polarity_i,
    output logic            pwm_o
);
    logic [7:0] cnt;
    logic [8:0] width;

    // Index to pulse width, 0..256 counts of 256
    function automatic logic [8:0] curve(input logic [7:0] idx, input logic use_log);
        logic [12:0] v;
        v = 13'(({7'h00, 1'b1, idx[4:0]} << idx[7:5]) >> 5);
        if (idx == 8'h00)
            curve = 9'h000;
        else if (idx == 8'hFF)
            curve = 9'h100;
        else if (use_log)
            curve = v[8:0];
        else
            curve = {1'b0, idx} + 9'h001;
    endfunction

    // Separate mapping for inverted polarity
    always_comb
    begin
        width = curve(level_i, log_sel_i);
        if (!polarity_i)
            width = log_sel_i ? 9'h100 - width : 9'h100 - {1'b0, level_i};
    end

    // Free-running period counter at the PWM rate
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt <= 8'h00;
        else if (pwm_tick_i)
            cnt <= cnt + 8'h01;
    end

    // Active while counter is below the pulse width
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            pwm_o <= 1'b0;
        else
            pwm_o <= ({1'b0, cnt} < width);
    end
endmodule

// [src/led_pwm_fading_gpio.sv]
// Eight LED pins with host PWM, fading output and special output modes
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module led_pwm_fading_gpio
#(
    parameter int unsigned FADE_UNIT_CYCLES = led_pwm_pkg::FADE_UNIT_CYCLES
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    input  wire logic [7:0]  button_i,
    input  wire logic [7:0]  prox_i,
    input  wire logic [7:0]  special_out_i,
    input  wire logic [7:0]  gpio_i,
    output logic [7:0]       gpio_o,
    output logic [7:0]       gpio_oe_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] pin_mode_cfg;
    logic [7:0]  pin_polarity_cfg;
    logic [7:0]  pin_powerup_level_cfg;
    logic [7:0]  on_intensity_cfg;
    logic [7:0]  off_intensity_cfg;
    logic [31:0] pin_function_cfg;
    logic [31:0] fade_cfg;
    logic [7:0]  host_cmd;
    logic [7:0]  prox_intensity_cfg;
    logic [2:0]  host_pwm_pin_select;
    logic [7:0]  host_pwm_level [8];
    logic [7:0]  strap;
    logic [4:0]  strap_cnt;
    logic        ready;
    logic        init_pulse;
    logic [4:0]  pwm_div;
    logic        pwm_tick;
    logic [31:0] unit_div;
    logic        unit_tick;
    logic        wr_en;
    logic        rd_take;
    logic [31:0] next_readdata;
    logic [7:0]  level [8];
    logic [7:0]  pwm_raw;
    logic [7:0]  fading;
    logic [11:0] inc_period;
    logic [11:0] dec_period;

    // Mode of one pin from the packed mode register
    function automatic logic [1:0] mode_of(input logic [15:0] m, input int unsigned p);
        mode_of = m[2*p +: 2];
    endfunction

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        for (int b = 0; b < 4; b++)
            be_merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    endfunction

    // ------------------------------------------------------------
    // Rate dividers
    // ------------------------------------------------------------

    // 2 MHz PWM enable
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pwm_div  <= 5'h00;
            pwm_tick <= 1'b0;
        end
        else if (pwm_div == 5'(led_pwm_pkg::PWM_DIV_CYCLES - 1))
        begin
            pwm_div  <= 5'h00;
            pwm_tick <= 1'b1;
        end
        else
        begin
            pwm_div  <= pwm_div + 5'h01;
            pwm_tick <= 1'b0;
        end
    end

    // Fade time unit enable
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            unit_div  <= 32'h0000_0000;
            unit_tick <= 1'b0;
        end
        else if (unit_div >= FADE_UNIT_CYCLES - 1)
        begin
            unit_div  <= 32'h0000_0000;
            unit_tick <= 1'b1;
        end
        else
        begin
            unit_div  <= unit_div + 32'h0000_0001;
            unit_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power-up phase and strap capture
    // ------------------------------------------------------------

    // Pins stay undriven and are sampled only in this phase
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            strap_cnt  <= 5'h00;
            ready      <= 1'b0;
            init_pulse <= 1'b0;
            strap      <= 8'h00;
        end
        else if (!ready)
        begin
            strap_cnt <= strap_cnt + 5'h01;
            if (strap_cnt == 5'(led_pwm_pkg::STRAP_CYCLES - 1))
            begin
                strap      <= gpio_i;
                ready      <= 1'b1;
                init_pulse <= 1'b1;
            end
        end
        else
            init_pulse <= 1'b0;
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    assign wr_en   = write_i && !waitrequest_o;
    assign rd_take = read_i && waitrequest_o;

    // One wait cycle per access, then answer
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            waitrequest_o <= 1'b1;
        else
            waitrequest_o <= !((read_i || write_i) && waitrequest_o);
    end

    // Read mux, unmapped reads as zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (address_i == led_pwm_pkg::REG_MODE)
            next_readdata = {16'h0000, pin_mode_cfg};
        else if (address_i == led_pwm_pkg::REG_POLARITY)
            next_readdata = {24'h000000, pin_polarity_cfg};
        else if (address_i == led_pwm_pkg::REG_POWERUP)
            next_readdata = {24'h000000, pin_powerup_level_cfg};
        else if (address_i == led_pwm_pkg::REG_ON_INT)
            next_readdata = {24'h000000, on_intensity_cfg};
        else if (address_i == led_pwm_pkg::REG_OFF_INT)
            next_readdata = {24'h000000, off_intensity_cfg};
        else if (address_i == led_pwm_pkg::REG_FUNCTION)
            next_readdata = pin_function_cfg;
        else if (address_i == led_pwm_pkg::REG_FADE)
            next_readdata = fade_cfg;
        else if (address_i == led_pwm_pkg::REG_HOST_PWM)
            next_readdata = {16'h0000, host_pwm_level[host_pwm_pin_select], 5'h00, host_pwm_pin_select};
        else if (address_i == led_pwm_pkg::REG_HOST_CMD)
            next_readdata = {24'h000000, host_cmd};
        else if (address_i == led_pwm_pkg::REG_PROX_INT)
            next_readdata = {24'h000000, prox_intensity_cfg};
        else if (address_i == led_pwm_pkg::REG_STATUS)
            next_readdata = {7'h00, ready, strap, fading, gpio_o};
    end

    // Read data captured in the wait cycle
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            readdata_o <= 32'h0000_0000;
        else if (rd_take)
            readdata_o <= next_readdata;
    end

    // Configuration registers
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_mode_cfg          <= led_pwm_pkg::RST_MODE;
            pin_polarity_cfg      <= led_pwm_pkg::RST_POLARITY;
            pin_powerup_level_cfg <= led_pwm_pkg::RST_POWERUP;
            on_intensity_cfg      <= led_pwm_pkg::RST_ON_INT;
            off_intensity_cfg     <= led_pwm_pkg::RST_OFF_INT;
            pin_function_cfg      <= led_pwm_pkg::RST_FUNCTION;
            fade_cfg              <= led_pwm_pkg::RST_FADE;
            host_cmd              <= 8'h00;
            prox_intensity_cfg    <= led_pwm_pkg::RST_PROX_INT;
        end
        else if (wr_en)
        begin
            if (address_i == led_pwm_pkg::REG_MODE)
                pin_mode_cfg <= 16'(be_merge({16'h0000, pin_mode_cfg},
                                             writedata_i, byteenable_i));
            else if (address_i == led_pwm_pkg::REG_POLARITY && byteenable_i[0])
                pin_polarity_cfg <= writedata_i[7:0];
            else if (address_i == led_pwm_pkg::REG_POWERUP && byteenable_i[0])
                pin_powerup_level_cfg <= writedata_i[7:0];
            else if (address_i == led_pwm_pkg::REG_ON_INT && byteenable_i[0])
                on_intensity_cfg <= writedata_i[7:0];
            else if (address_i == led_pwm_pkg::REG_OFF_INT && byteenable_i[0])
                off_intensity_cfg <= writedata_i[7:0];
            else if (address_i == led_pwm_pkg::REG_FUNCTION)
                pin_function_cfg <= be_merge(pin_function_cfg, writedata_i, byteenable_i);
            else if (address_i == led_pwm_pkg::REG_FADE)
                fade_cfg <= be_merge(fade_cfg, writedata_i, byteenable_i);
            else if (address_i == led_pwm_pkg::REG_HOST_CMD && byteenable_i[0])
                host_cmd <= writedata_i[7:0];
            else if (address_i == led_pwm_pkg::REG_PROX_INT && byteenable_i[0])
                prox_intensity_cfg <= writedata_i[7:0];
        end
    end

    // Host PWM levels, seeded at the end of power-up
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            host_pwm_pin_select <= 3'h0;
            for (int p = 0; p < 8; p++)
                host_pwm_level[p] <= 8'h00;
        end
        else if (init_pulse)
        begin
            for (int p = 0; p < 8; p++)
                host_pwm_level[p] <= pin_powerup_level_cfg[p] ? on_intensity_cfg
                                                                : off_intensity_cfg;
        end
        else if (wr_en && address_i == led_pwm_pkg::REG_HOST_PWM)
        begin
            if (byteenable_i[0])
                host_pwm_pin_select <= writedata_i[led_pwm_pkg::HP_SEL_LSB +: 3];
            if (byteenable_i[1])
                host_pwm_level[byteenable_i[0] ? writedata_i[2:0] : host_pwm_pin_select]
                    <= writedata_i[led_pwm_pkg::HP_LEVEL_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // Fading engines and PWM generators
    // ------------------------------------------------------------

    // Step periods in fade units, time times factor
    assign inc_period = 12'(fade_cfg[led_pwm_pkg::FD_INC_T_LSB +: 8]
                            * fade_cfg[led_pwm_pkg::FD_INC_F_LSB +: 4]);
    assign dec_period = 12'(fade_cfg[led_pwm_pkg::FD_DEC_T_LSB +: 8]
                            * fade_cfg[led_pwm_pkg::FD_DEC_F_LSB +: 4]);

    for (genvar g = 0; g < 8; g++)
    begin : g_pin
        logic [11:0] scnt;
        logic [7:0]  dcnt;
        logic        down;
        logic        was_on;
        logic        want_on;
        logic        cont;
        logic [7:0]  target;
        logic [7:0]  goal;
        logic        up;
        logic [11:0] period;
        logic [7:0]  time_sel;

        assign cont    = pin_function_cfg[led_pwm_pkg::FN_CONT_LSB + g];
        assign want_on = pin_function_cfg[led_pwm_pkg::FN_AUTO_LSB + g] ?
                         button_i[g] : host_cmd[g];
        assign target  = want_on ? on_intensity_cfg :
                         (pin_function_cfg[led_pwm_pkg::FN_TRIPLE_LSB + g] && prox_i[g]) ?
                         prox_intensity_cfg : off_intensity_cfg;
        assign goal    = down ? off_intensity_cfg : target;
        assign up      = goal > level[g];
        assign period  = up ? inc_period : dec_period;
        assign time_sel = up ? fade_cfg[led_pwm_pkg::FD_INC_T_LSB +: 8]
                             : fade_cfg[led_pwm_pkg::FD_DEC_T_LSB +: 8];
        assign fading[g] = (level[g] != goal) || (dcnt != 8'h00);

        // Intensity index walk for one pin
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                level[g] <= 8'h00;
                scnt     <= 12'h000;
                dcnt     <= 8'h00;
                down     <= 1'b0;
                was_on   <= 1'b0;
            end
            else if (!ready)
                level[g] <= 8'h00;
            else if (mode_of(pin_mode_cfg, g) != led_pwm_pkg::fading_output_mode)
            begin
                level[g] <= host_pwm_level[g];
                scnt     <= 12'h000;
                dcnt     <= 8'h00;
                down     <= 1'b0;
                was_on   <= 1'b0;
            end
            else
            begin
                was_on <= want_on;
                if (was_on && !want_on)
                begin
                    dcnt <= fade_cfg[led_pwm_pkg::FD_DELAY_LSB +: 8];
                    scnt <= 12'h000;
                    down <= 1'b0;
                end
                else if (dcnt != 8'h00)
                begin
                    if (unit_tick)
                        dcnt <= dcnt - 8'h01;
                end
                else if (level[g] == goal)
                begin
                    scnt <= 12'h000;
                    down <= cont && want_on && (goal == on_intensity_cfg);
                end
                else if (time_sel == 8'h00)
                    level[g] <= goal;
                else if (unit_tick)
                begin
                    if (scnt + 12'h001 >= period)
                    begin
                        scnt     <= 12'h000;
                        level[g] <= up ? level[g] + 8'h01 : level[g] - 8'h01;
                    end
                    else
                        scnt <= scnt + 12'h001;
                end
            end
        end

        pwm_channel u_pwm
        (
            .ref_clk_i  (ref_clk_i),
            .rst_i      (rst_i),
            .pwm_tick_i (pwm_tick),
            .level_i    (level[g]),
            .log_sel_i  (pin_function_cfg[led_pwm_pkg::FN_LOG_LSB + g]),
            .polarity_i (pin_polarity_cfg[g]),
            .pwm_o      (pwm_raw[g])
        );
    end

    // Pin drivers, special pins pass their source through
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gpio_o    <= 8'h00;
            gpio_oe_o <= 8'h00;
        end
        else
        begin
            for (int p = 0; p < 8; p++)
            begin
                gpio_oe_o[p] <= ready;
                gpio_o[p]    <= (mode_of(pin_mode_cfg, p) == led_pwm_pkg::host_pwm_mode ||
                                 mode_of(pin_mode_cfg, p) == led_pwm_pkg::fading_output_mode) ?
                                pwm_raw[p] : special_out_i[p];
            end
        end
    end
endmodule

// [test/led_pwm_sva.sv]
// Bus handshake and pin enable assertions for the LED PWM block
`timescale 1ns/1ps
module led_pwm_sva
#(
    parameter int unsigned FADE_UNIT_CYCLES = 4
)
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic [7:0]  gpio_oe_o
);
    logic [4:0] since_rel;

    // Edges since reset release, saturating
    always_ff @(posedge ref_clk_i or posedge rst_i)
        if (rst_i)
            since_rel <= 5'h00;
        else if (since_rel != 5'h1F)
            since_rel <= since_rel + 5'h01;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_req_answered: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("wait release lasted more than one cycle");
    a_ack_cause: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
        else $error("wait released without a request");
    a_idle_wait: assert property (!read_i && !write_i |=> waitrequest_o)
        else $error("wait released while idle");
    a_rdata_holds: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
        else $error("read data changed without a read");
    a_rdata_unmapped: assert property (read_i && waitrequest_o && address_i > 4'hA |=> readdata_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_oe_early: assert property (since_rel < 5'h10 |-> gpio_oe_o == 8'h00)
        else $error("pin driven during power-up phase");
    a_oe_driving: assert property (since_rel > 5'h13 |-> gpio_oe_o == 8'hFF)
        else $error("pin not driven after power-up phase");
endmodule

bind led_pwm_fading_gpio led_pwm_sva #(.FADE_UNIT_CYCLES(FADE_UNIT_CYCLES)) chk_u
(
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .gpio_oe_o(gpio_oe_o)
);

// [test/led_load.sv]
// LED load model with strap resistors on each pin
`timescale 1ns/1ps
module led_load
#(
    parameter logic [7:0] STRAP = 8'hA5
)
(
    input  wire logic [7:0] pin_level_i,
    input  wire logic [7:0] pin_en_i,
    output logic [7:0]      pin_o
);
    // Driven pins read back the driver, released pins the strap level
    always_comb
        for (int i = 0; i < 8; i++)
            pin_o[i] = pin_en_i[i] ? pin_level_i[i] : STRAP[i];
endmodule

// [test/testbench.sv]
// Self-checking bench for the LED PWM and fading pin block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk_i, rst_i, read_i, write_i, waitrequest_o;
    logic [3:0]  address_i, byteenable_i;
    logic [31:0] writedata_i, readdata_o, rd;
    logic [7:0]  button_i, prox_i, special_out_i, gpio_i, gpio_o, gpio_oe_o;
    int          fail_count, n_compared, cyc;

    led_pwm_fading_gpio #(.FADE_UNIT_CYCLES(4)) dut_u
    (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .button_i(button_i), .prox_i(prox_i),
        .special_out_i(special_out_i), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o)
    );
    led_load load_u (.pin_level_i(gpio_o), .pin_en_i(gpio_oe_o), .pin_o(gpio_i));

    // Clock and hang guard
    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 97000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus access, held until the wait release is sampled
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk_i);
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        read_i <= !wr;
        write_i <= wr;
        do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    // High cycles of one pin over one full PWM period after settling
    task automatic duty(input string what, input int pin, input int exp);
        int hi;
        hi = 0;
        repeat (600) @(posedge ref_clk_i);
        repeat (5120) @(posedge ref_clk_i) hi += (gpio_o[pin] === 1'b1);
        check(what, hi, exp);
    endtask

    task automatic t_powerup();
        wr(led_pwm_pkg::REG_POWERUP, 32'h02);
        repeat (30) @(posedge ref_clk_i);
        bus(1'b0, led_pwm_pkg::REG_STATUS, 32'h0, 4'hF);
        check("strap and ready", rd[24:16], 9'h1A5);
        bus(1'b1, led_pwm_pkg::REG_HOST_PWM, 32'h01, 4'h1);
        bus(1'b0, led_pwm_pkg::REG_HOST_PWM, 32'h0, 4'hF);
        check("seeded level", rd[15:0], 16'hFF01);
        wr(4'hF, 32'hFFFF_FFFF);
        bus(1'b0, 4'hF, 32'h0, 4'hF);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_host();
        wr(led_pwm_pkg::REG_MODE, 32'h0001);
        wr(led_pwm_pkg::REG_HOST_PWM, 32'h3F00);
        duty("host linear", 0, 64 * 20);
        wr(led_pwm_pkg::REG_FUNCTION, 32'h01FF);
        duty("host log", 0, 3 * 20);
        wr(led_pwm_pkg::REG_POLARITY, 32'hFE);
        duty("host inverted", 0, 253 * 20);
        wr(led_pwm_pkg::REG_FUNCTION, 32'h00FF);
        duty("host lin inverted", 0, 193 * 20);
    endtask

    task automatic t_output();
        button_i[1] <= 1'b1;
        duty("auto on", 1, 5120);
        button_i[1] <= 1'b0;
        duty("auto off", 1, 0);
        wr(led_pwm_pkg::REG_FUNCTION, 32'h0400_01FD);
        wr(led_pwm_pkg::REG_HOST_CMD, 32'h02);
        duty("host on", 1, 5120);
        button_i[1] <= 1'b1;
        wr(led_pwm_pkg::REG_HOST_CMD, 32'h00);
        duty("button ignored", 1, 0);
        prox_i[2] <= 1'b1;
        duty("proximity level", 2, 65 * 20);
        wr(led_pwm_pkg::REG_MODE, 32'h0081);
        special_out_i[3] <= 1'b1;
        duty("special source", 3, 5120);
    endtask

    task automatic t_fade(input logic [31:0] fn, input string what);
        int hi;
        button_i[1] <= 1'b0;
        wr(led_pwm_pkg::REG_FUNCTION, fn);
        wr(led_pwm_pkg::REG_FADE, 32'hFF10_1102);
        repeat (2000) @(posedge ref_clk_i);
        button_i[1] <= 1'b1;
        repeat (100) @(posedge ref_clk_i);
        bus(1'b0, led_pwm_pkg::REG_STATUS, 32'h0, 4'hF);
        check("fade in busy", rd[9], 1'b1);
        repeat (2500) @(posedge ref_clk_i);
        bus(1'b0, led_pwm_pkg::REG_STATUS, 32'h0, 4'hF);
        check(what, rd[9], fn[17]);
        button_i[1] <= 1'b0;
        hi = 0;
        repeat (20) @(posedge ref_clk_i);
        repeat (900) @(posedge ref_clk_i) hi += (gpio_o[1] === 1'b1);
        if (!fn[17])
            check("off delay", hi, 900);
        repeat (1500) @(posedge ref_clk_i);
        duty("faded out", 1, 0);
    endtask

    // Main sequence
    initial
    begin
        rst_i = 1'b1;
        {read_i, write_i, address_i, writedata_i, byteenable_i} = '0;
        {button_i, prox_i, special_out_i} = '0;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_powerup();
        t_host();
        t_output();
        t_fade(32'h0000_01FF, "single settles");
        t_fade(32'h0002_01FF, "continuous cycles");
        summarize();
    end
endmodule
